// ### hdl/rcf_pkg.sv
// Package for the raster coverage front end: register map, field layout,
// carrier structs and fixed sizes. Assumes one clock, synchronous reset.
package rcf_pkg;

    // Register bus
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned DATA_W = 32;
    localparam logic [ADDR_W-1:0] REG_CTRL   = 4'h0;
    localparam logic [ADDR_W-1:0] REG_OFFSET = 4'h4;
    localparam logic [ADDR_W-1:0] REG_COUNT  = 4'h8;
    localparam logic [ADDR_W-1:0] REG_CAPS   = 4'hC;

    // Control fields
    localparam int unsigned CTRL_DISCARD = 0;
    localparam int unsigned CTRL_GEOM    = 1;
    localparam int unsigned CTRL_RGBA    = 2;
    localparam int unsigned CTRL_MS_EN   = 3;
    localparam int unsigned CTRL_SBUF    = 4;
    localparam int unsigned CTRL_IDXW_LO = 8;
    localparam int unsigned IDXW_W       = 4;
    localparam logic [DATA_W-1:0] CTRL_RESET = 32'h0000_0C0C;

    // Status fields
    localparam int unsigned CAPS_MS_ACT  = 0;
    localparam int unsigned CAPS_DS_PRES = 1;
    localparam int unsigned CAPS_AAB_LO  = 4;
    localparam int unsigned CNT_W        = 16;
    localparam int unsigned CNT_DROP_LO  = 16;

    // Fixed sizes
    localparam int unsigned COORD_W  = 16;
    localparam int unsigned COV_W    = 8;
    localparam int unsigned CH_W     = 8;
    localparam int unsigned CI_W     = 12;
    localparam int unsigned SAMPLES  = 4;
    localparam int unsigned AA_MAX_B = 4;
    localparam int unsigned STREAM_W = 2;
    localparam logic [STREAM_W-1:0] STREAM_ZERO = 2'h0;
    localparam logic [COV_W-1:0]    COV_FULL    = 8'hFF;
    localparam logic [15:0]         COV_ROUND   = 16'h007F;

    typedef enum logic [2:0] {
        ITEM_PRIM   = 3'h0,
        ITEM_ACCUM  = 3'h1,
        ITEM_BITMAP = 3'h2,
        ITEM_COPY   = 3'h3,
        ITEM_DRAW   = 3'h4,
        ITEM_CLEAR  = 3'h5
    } rcf_item_type;

    typedef struct packed {
        rcf_item_type            kind;
        logic [STREAM_W-1:0]     stream;
        logic [COORD_W-1:0]      x;
        logic [COORD_W-1:0]      y;
        logic [COV_W-1:0]        cov;
        logic [SAMPLES-1:0]      mask;
        logic [4*CH_W-1:0]       rgba;
        logic [CI_W-1:0]         index;
    } rcf_in_type;

    typedef struct packed {
        rcf_item_type            kind;
        logic [COORD_W-1:0]      x;
        logic [COORD_W-1:0]      y;
        logic [COORD_W:0]        cx;
        logic [COORD_W:0]        cy;
        logic [SAMPLES-1:0]      mask;
        logic [4*CH_W-1:0]       rgba;
        logic [CI_W-1:0]         index;
    } rcf_out_type;

endpackage : rcf_pkg

// ### hdl/rcf_front_end.sv
// Raster coverage front end: stream filter, discard switch, grid placement,
// coverage antialiasing and multisample mask shaping, plus register port.
// Assumes upstream supplies per-fragment coverage computed from edge
// relations only, and downstream drains through a valid/ready handshake.

// What this block does
// - Pass stream zero, drop other streams.
// - Geometry stage off means stream zero.
// - Discard enable drops all primitives.
// - Discard enable also ignores pixel commands.
// - Integer offset moves fragments unchanged otherwise.
// - Fragment addressed by integer lower-left corner.
// - Center is corner plus one half.
// - RGBA keeps RGB, alpha times coverage.
// - Index mode uses min(4, width) bits.
// - Index bits scale zero to all ones.
// - Coverage scaling is monotonic.
// - Coverage ignores absolute x and y.
// - Summed coverage kept under rigid motion.
// - Coverage models uniform unit box.
// - Sample buffer one selects multisample.
// - Multisample mask one bit per sample.
// - Multisample buffer excludes depth and stencil.
// - Samples resolved to one color each update.
// - Multisample off gives full coverage mask.
module rcf_front_end
    import rcf_pkg::*;
(
    input  wire logic                CLOCK,
    input  wire logic                RST_N,
    input  wire logic [ADDR_W-1:0]   REG_ADDR,
    input  wire logic [DATA_W-1:0]   REG_WDATA,
    input  wire logic                REG_WR,
    input  wire logic                REG_RD,
    output logic      [DATA_W-1:0]   REG_RDATA,
    input  wire logic                IN_VALID,
    output logic                     IN_READY,
    input  wire rcf_in_type          IN_ITEM,
    output logic                     OUT_VALID,
    input  wire logic                OUT_READY,
    output rcf_out_type              OUT_ITEM
);

    // Round-to-nearest scale by a coverage in [0,1]; monotonic in cov
    function automatic logic [CH_W-1:0] cov_scale(input logic [CH_W-1:0]  val,
                                                  input logic [COV_W-1:0] cov);
        logic [15:0] prod;
        prod = 16'(val) * 16'(cov) + COV_ROUND;
        return CH_W'(prod / 16'(COV_FULL));
    endfunction

    logic [DATA_W-1:0]  ctrl_q;
    logic [DATA_W-1:0]  offset_q;
    logic [CNT_W-1:0]   pass_cnt_q;
    logic [CNT_W-1:0]   drop_cnt_q;
    logic [DATA_W-1:0]  rdata_q;
    logic               out_valid_q;
    rcf_out_type        out_q;
    rcf_out_type        out_d;

    logic               discard_en;
    logic               geom_en;
    logic               rgba_mode;
    logic               ms_en;
    logic               ms_active;
    logic [IDXW_W-1:0]  idx_width;
    logic [2:0]         aa_bits;
    logic [CI_W-1:0]    aa_field;
    logic               eff_stream0;
    logic               drop;
    logic               take;
    logic [SAMPLES-1:0] eff_mask;
    logic [COV_W-1:0]   eff_cov;
    logic [2:0]         mask_pop;

    assign discard_en = ctrl_q[CTRL_DISCARD];
    assign geom_en    = ctrl_q[CTRL_GEOM];
    assign rgba_mode  = ctrl_q[CTRL_RGBA];
    assign ms_en      = ctrl_q[CTRL_MS_EN];
    assign ms_active  = ctrl_q[CTRL_SBUF];
    assign idx_width  = ctrl_q[CTRL_IDXW_LO +: IDXW_W];
    assign aa_bits    = (idx_width > IDXW_W'(AA_MAX_B)) ?
                        3'(AA_MAX_B) : idx_width[2:0];

    // Register write side
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctrl_q   <= CTRL_RESET;
            offset_q <= '0;
        end else if (REG_WR) begin
            if (REG_ADDR == REG_CTRL) begin
                ctrl_q <= REG_WDATA;
            end
            if (REG_ADDR == REG_OFFSET) begin
                offset_q <= REG_WDATA;
            end
        end
    end

    // Read data stands for exactly the cycle after the strobe
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            rdata_q <= '0;
        end else if (REG_RD) begin
            case (REG_ADDR)
                REG_CTRL:   rdata_q <= ctrl_q;
                REG_OFFSET: rdata_q <= offset_q;
                REG_COUNT:  rdata_q <= {drop_cnt_q, pass_cnt_q};
                REG_CAPS: begin
                    rdata_q                 <= '0;
                    rdata_q[CAPS_MS_ACT]    <= ms_active;
                    rdata_q[CAPS_DS_PRES]   <= ~ms_active;
                    rdata_q[CAPS_AAB_LO +: 3] <= aa_bits;
                end
                default:    rdata_q <= '0;
            endcase
        end else begin
            rdata_q <= '0;
        end
    end

    assign REG_RDATA = rdata_q;

    // Item acceptance and filtering
    assign eff_stream0 = !geom_en || (IN_ITEM.stream == STREAM_ZERO);
    assign drop        = discard_en || !eff_stream0;
    assign IN_READY    = !out_valid_q || OUT_READY;
    assign take        = IN_VALID && IN_READY;

    // Counters: a write clears, an event in the same cycle still counts
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            pass_cnt_q <= '0;
            drop_cnt_q <= '0;
        end else begin
            if (REG_WR && REG_ADDR == REG_COUNT) begin
                pass_cnt_q <= CNT_W'(take && !drop);
                drop_cnt_q <= CNT_W'(take && drop);
            end else begin
                pass_cnt_q <= pass_cnt_q + CNT_W'(take && !drop);
                drop_cnt_q <= drop_cnt_q + CNT_W'(take && drop);
            end
        end
    end

    // Mask pop count for the resolve step
    always_comb begin
        mask_pop = '0;
        for (int i = 0; i < SAMPLES; i++) begin
            mask_pop = mask_pop + 3'(eff_mask[i]);
        end
    end

    // Coverage selection; coverage never looks at x or y
    always_comb begin
        eff_mask = '1;
        eff_cov  = IN_ITEM.cov;
        if (ms_active) begin
            eff_mask = ms_en ? IN_ITEM.mask : '1;
            eff_cov  = COV_W'((16'(mask_pop) * 16'(COV_FULL)) / 16'(SAMPLES));
        end
    end

    assign aa_field = CI_W'((1 << aa_bits) - 1);

    // Fragment build
    always_comb begin
        logic [CH_W-1:0] scaled_idx;
        scaled_idx      = cov_scale(CH_W'(aa_field), eff_cov);
        out_d           = '0;
        out_d.kind      = IN_ITEM.kind;
        out_d.x         = IN_ITEM.x + offset_q[COORD_W-1:0];
        out_d.y         = IN_ITEM.y + offset_q[DATA_W-1:COORD_W];
        out_d.cx        = {out_d.x, 1'b1};
        out_d.cy        = {out_d.y, 1'b1};
        out_d.mask      = eff_mask;
        out_d.rgba      = IN_ITEM.rgba;
        out_d.index     = IN_ITEM.index;
        if (rgba_mode) begin
            out_d.rgba[CH_W-1:0] = cov_scale(IN_ITEM.rgba[CH_W-1:0], eff_cov);
        end else begin
            out_d.index = (IN_ITEM.index & ~aa_field) |
                          (CI_W'(scaled_idx) & aa_field);
        end
    end

    // Output stage held while downstream stalls
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            out_valid_q <= 1'b0;
            out_q       <= '0;
        end else if (IN_READY) begin
            out_valid_q <= take && !drop;
            if (take && !drop) begin
                out_q <= out_d;
            end
        end
    end

    assign OUT_VALID = out_valid_q;
    assign OUT_ITEM  = out_q;

endmodule // rcf_front_end

// ### dv/rcf_monitor.sv
// Port checker for the raster coverage front end.
// Assumes control and offset are only rewritten while no item is in flight.
module rcf_monitor
    import rcf_pkg::*;
(
    input wire logic              CLOCK,
    input wire logic              RST_N,
    input wire logic [ADDR_W-1:0] REG_ADDR,
    input wire logic [DATA_W-1:0] REG_WDATA,
    input wire logic              REG_WR,
    input wire logic              REG_RD,
    input wire logic [DATA_W-1:0] REG_RDATA,
    input wire logic              IN_VALID,
    input wire logic              IN_READY,
    input wire rcf_in_type        IN_ITEM,
    input wire logic              OUT_VALID,
    input wire logic              OUT_READY,
    input wire rcf_out_type       OUT_ITEM
);
    logic [DATA_W-1:0] ctl_q;
    logic [DATA_W-1:0] off_q;
    logic              acc;
    logic              drop;
    always_ff @(posedge CLOCK) begin
        if (!RST_N) begin
            ctl_q <= CTRL_RESET;
            off_q <= '0;
        end else if (REG_WR && REG_ADDR == REG_CTRL) begin
            ctl_q <= REG_WDATA;
        end else if (REG_WR && REG_ADDR == REG_OFFSET) begin
            off_q <= REG_WDATA;
        end
    end
    assign acc = IN_VALID && IN_READY;
    assign drop = ctl_q[CTRL_DISCARD] || (ctl_q[CTRL_GEOM] && IN_ITEM.stream != STREAM_ZERO);
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RST_N);
    AST_RDATA_IDLE: assert property (!$past(REG_RD) |-> REG_RDATA == '0)
        else $error("read data not idle");
    AST_READY: assert property (IN_READY == (!OUT_VALID || OUT_READY))
        else $error("ready wrong");
    AST_HOLD: assert property (OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_ITEM))
        else $error("output not held");
    AST_DROP: assert property (acc && drop |=> !OUT_VALID)
        else $error("item not dropped");
    AST_KEEP: assert property (acc && !drop |=> OUT_VALID
        && OUT_ITEM.kind == $past(IN_ITEM.kind))
        else $error("item lost");
    AST_OFFSET: assert property (acc && !drop
        |=> OUT_ITEM.x == $past(IN_ITEM.x) + off_q[15:0])
        else $error("offset wrong");
    AST_CENTER: assert property (OUT_VALID |-> OUT_ITEM.cx == {OUT_ITEM.x, 1'b1}
        && OUT_ITEM.cy == {OUT_ITEM.y, 1'b1})
        else $error("center wrong");
    AST_RGB: assert property (acc && !drop && ctl_q[CTRL_RGBA]
        |=> OUT_ITEM.rgba[31:8] == $past(IN_ITEM.rgba[31:8]))
        else $error("rgb changed");
    AST_FULLMASK: assert property (OUT_VALID && !(ctl_q[CTRL_SBUF] && ctl_q[CTRL_MS_EN])
        |-> OUT_ITEM.mask == 4'hF)
        else $error("mask not full");
endmodule // rcf_monitor

bind rcf_front_end rcf_monitor u_mon (.CLOCK(CLOCK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
    .IN_VALID(IN_VALID), .IN_READY(IN_READY), .IN_ITEM(IN_ITEM), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_ITEM(OUT_ITEM));

// ### dv/rcf_sink.sv
// Downstream stage model: takes fragments, stalls at random when slow.
// Assumes it shares clock and reset with the front end.
module rcf_sink (
    input wire logic clock,
    input wire logic rst_n,
    input wire logic slow,
    output logic     ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 32'h2318;
    always_ff @(posedge clock) begin
        if (!rst_n) ready <= 1'b0;
        else ready <= !slow || ($random(seed) & 1);
    end
endmodule // rcf_sink

// ### dv/rcf_front_end_tb.sv
// Self-checking bench for the raster coverage front end.
// Assumes the bound checker and the downstream model in dv/.
module rcf_front_end_tb;
    import rcf_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clock, rst_n, reg_wr, reg_rd, in_valid, in_ready, out_valid;
    logic              out_ready, slow;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, c, off;
    logic [DATA_W-1:0] cfg [6] = '{32'h0C0C, 32'h0208, 32'h041E, 32'h0314, 32'h0118, 32'h0C0D};
    logic [95:0]       r;
    rcf_in_type        in_item, it;
    rcf_out_type       out_item;
    rcf_out_type       q[$];
    int                n_errors, compares, np, nd, k;
    int                seed = 32'h2318;
    rcf_front_end DUT (.CLOCK(clock), .RST_N(rst_n), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
        .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .IN_VALID(in_valid),
        .IN_READY(in_ready), .IN_ITEM(in_item), .OUT_VALID(out_valid), .OUT_READY(out_ready),
        .OUT_ITEM(out_item));
    rcf_sink u_sink (.clock(clock), .rst_n(rst_n), .slow(slow), .ready(out_ready));
    initial begin
        clock = 0;
        forever #5 clock = ~clock;
    end
    task automatic summarize();
        $display("n_errors=%0d compares=%0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_reg(logic [DATA_W-1:0] g, logic [DATA_W-1:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic chk_frag(rcf_out_type g, rcf_out_type e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
        reg_wr <= 1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 0;
        // Idle edge so two writes in a row never drive the strobe twice at once
        @(posedge clock);
    endtask
    task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
        reg_rd <= 1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 0;
        @(posedge clock);
        chk_reg(reg_rdata, e);
    endtask
    function automatic rcf_out_type ef(rcf_in_type i);
        rcf_out_type o;
        int b, cv;
        o = '0;
        o.kind = i.kind;
        o.x = i.x + off[15:0];
        o.y = i.y + off[31:16];
        o.cx = {o.x, 1'b1};
        o.cy = {o.y, 1'b1};
        o.mask = (c[4] && c[3]) ? i.mask : 4'hF;
        cv = c[4] ? $countones(o.mask) * 255 / 4 : i.cov;
        o.rgba = i.rgba;
        o.index = i.index;
        b = (c[11:8] < 4) ? c[11:8] : 4;
        if (c[2]) o.rgba[7:0] = 8'((i.rgba[7:0] * cv + 127) / 255);
        else o.index = ((i.index >> b) << b) | CI_W'((((1 << b) - 1) * cv + 127) / 255);
        return o;
    endfunction
    function automatic logic [DATA_W-1:0] ecaps(logic [DATA_W-1:0] v);
        logic [DATA_W-1:0] s;
        s = '0;
        s[0] = v[4];
        s[1] = !v[4];
        s[6:4] = (v[11:8] < 4) ? 3'(v[11:8]) : 3'h4;
        return s;
    endfunction
    task automatic send(rcf_in_type i);
        in_valid <= 1;
        in_item <= i;
        for (k = 0; k < 100; k++) begin
            @(posedge clock);
            if (in_ready) break;
        end
        if (k == 100) n_errors++;
        if (c[0] || (c[1] && i.stream != STREAM_ZERO)) nd++;
        else q.push_back(ef(i));
        if (!(c[0] || (c[1] && i.stream != STREAM_ZERO))) np++;
    endtask
    always @(posedge clock)
        if (rst_n && out_valid && out_ready)
            chk_frag(out_item, q.pop_front());
    initial begin
        #300000;
        n_errors++;
        summarize();
    end
    initial begin
        {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, in_valid, slow} = '0;
        in_item = '0;
        c = CTRL_RESET;
        off = '0;
        repeat (5) @(posedge clock);
        rst_n <= 1;
        rd(REG_CTRL, CTRL_RESET);
        wr(4'h2, 32'hFFFF_FFFF);
        rd(4'h2, 32'h0);
        wr(REG_CAPS, 32'hFFFF_FFFF);
        rd(REG_CAPS, ecaps(CTRL_RESET));
        foreach (cfg[j]) begin
            c = cfg[j];
            off = $random(seed);
            slow <= j[0];
            np = 0;
            nd = 0;
            wr(REG_CTRL, c);
            wr(REG_OFFSET, off);
            wr(REG_COUNT, 32'h0);
            for (int n = 0; n < 24; n++) begin
                r = {$random(seed), $random(seed), $random(seed)};
                it = r[92:0];
                it.kind = rcf_item_type'(n % 6);
                send(it);
            end
            in_valid <= 0;
            for (k = 0; k < 500 && q.size() > 0; k++) @(posedge clock);
            // Fragments never delivered count as an error
            if (q.size() > 0) n_errors++;
            rd(REG_CTRL, c);
            rd(REG_CAPS, ecaps(c));
            rd(REG_COUNT, {nd[15:0], np[15:0]});
        end
        summarize();
    end
endmodule // rcf_front_end_tb
